// ---- status_flags_cfg.svh ----
// Offsets, bit positions and reset values of the CPU status register
`ifndef STATUS_FLAGS_CFG_SVH
`define STATUS_FLAGS_CFG_SVH

// ==========================================================
// Location in data memory
`define STATUS_ADDR 8'h03

// ==========================================================
// Field positions
`define BANK_MSB 7
`define BANK_LSB 5
`define TIMEOUT_BIT 4
`define POWERDOWN_BIT 3
`define ZERO_BIT 2
`define DIGIT_CARRY_BIT 1
`define CARRY_BIT 0

// ==========================================================
// Reset values
`define BANK_RESET 3'h0
`define TIMEOUT_POR 1'h1
`define POWERDOWN_POR 1'h1
`define READ_IDLE 8'h00

`endif

// ---- cpu_status_pkg.sv ----
// Types shared by the status register and its flag logic
package cpu_status_pkg;

  // ==========================================================
  // Instruction classes seen by the flag logic
  typedef enum logic [3:0] {
    OP_NONE           = 4'h0,
    OP_ADD            = 4'h1,
    OP_SUB            = 4'h2,
    OP_AND            = 4'h3,
    OP_CLEAR_REG      = 4'h4,
    OP_ROT_RIGHT      = 4'h5,
    OP_ROT_LEFT       = 4'h6,
    OP_BIT_CLEAR      = 4'h7,
    OP_BIT_SET        = 4'h8,
    OP_NIBBLE_SWAP    = 4'h9,
    OP_MOVE_W         = 4'ha,
    OP_CLEAR_WATCHDOG = 4'hb,
    OP_SLEEP          = 4'hc
  } alu_op_e;

endpackage

// ---- status_alu.sv ----
// Result and flag logic for instructions that touch the status flags
`timescale 1ns/1ps
`default_nettype none

module status_alu (
  input wire cpu_status_pkg::alu_op_e op_i,
  input wire logic [7:0] freg_i,
  input wire logic [7:0] w_i,
  input wire logic [2:0] bit_sel_i,
  input wire logic carry_i,
  output logic [7:0] result_o,
  output logic writes_f_o,
  output logic zero_o,
  output logic digit_carry_o,
  output logic carry_o,
  output logic zero_en_o,
  output logic digit_carry_en_o,
  output logic carry_en_o
);

  logic [8:0] sum;
  logic [4:0] low;

  // ==========================================================
  // Operation decode
  always_comb begin
    sum = 9'h000;
    low = 5'h00;
    result_o = 8'h00;
    writes_f_o = 1'b0;
    digit_carry_o = 1'b0;
    carry_o = 1'b0;
    zero_en_o = 1'b0;
    digit_carry_en_o = 1'b0;
    carry_en_o = 1'b0;
    case (op_i)
      cpu_status_pkg::OP_ADD: begin
        sum = {1'b0, freg_i} + {1'b0, w_i};
        low = {1'b0, freg_i[3:0]} + {1'b0, w_i[3:0]};
        result_o = sum[7:0];
        carry_o = sum[8];
        digit_carry_o = low[4];
        writes_f_o = 1'b1;
        {zero_en_o, digit_carry_en_o, carry_en_o} = 3'h7;
      end
      cpu_status_pkg::OP_SUB: begin
        // Two's complement add: carry set means no borrow
        sum = {1'b0, freg_i} + {1'b0, ~w_i} + 9'h001;
        low = {1'b0, freg_i[3:0]} + {1'b0, ~w_i[3:0]} + 5'h01;
        result_o = sum[7:0];
        carry_o = sum[8];
        digit_carry_o = low[4];
        writes_f_o = 1'b1;
        {zero_en_o, digit_carry_en_o, carry_en_o} = 3'h7;
      end
      cpu_status_pkg::OP_AND: begin
        result_o = freg_i & w_i;
        writes_f_o = 1'b1;
        zero_en_o = 1'b1;
      end
      cpu_status_pkg::OP_CLEAR_REG: begin
        result_o = 8'h00;
        writes_f_o = 1'b1;
        zero_en_o = 1'b1;
      end
      cpu_status_pkg::OP_ROT_RIGHT: begin
        result_o = {carry_i, freg_i[7:1]};
        carry_o = freg_i[0];
        writes_f_o = 1'b1;
        carry_en_o = 1'b1;
      end
      cpu_status_pkg::OP_ROT_LEFT: begin
        result_o = {freg_i[6:0], carry_i};
        carry_o = freg_i[7];
        writes_f_o = 1'b1;
        carry_en_o = 1'b1;
      end
      cpu_status_pkg::OP_BIT_CLEAR: begin
        result_o = freg_i & ~(8'h01 << bit_sel_i);
        writes_f_o = 1'b1;
      end
      cpu_status_pkg::OP_BIT_SET: begin
        result_o = freg_i | (8'h01 << bit_sel_i);
        writes_f_o = 1'b1;
      end
      cpu_status_pkg::OP_NIBBLE_SWAP: begin
        result_o = {freg_i[3:0], freg_i[7:4]};
        writes_f_o = 1'b1;
      end
      cpu_status_pkg::OP_MOVE_W: begin
        result_o = w_i;
        writes_f_o = 1'b1;
      end
      default: begin
        result_o = 8'h00;
      end
    endcase
    zero_o = (result_o == 8'h00);
  end

endmodule // status_alu

`default_nettype wire

// ---- reset_cause_flags.sv ----
// Time-out and power-down reset-cause bits
`timescale 1ns/1ps
`default_nettype none
`include "status_flags_cfg.svh"

module reset_cause_flags (
  input wire logic sys_clk_i,
  input wire logic por_i,
  input wire logic clear_watchdog_i,
  input wire logic sleep_i,
  input wire logic watchdog_timeout_i,
  output logic timeout_flag_o,
  output logic powerdown_flag_o
);

  logic timeout_d;
  logic powerdown_d;

  // ==========================================================
  // Next values; a time-out event beats a same-cycle set
  always_comb begin
    timeout_d = timeout_flag_o;
    powerdown_d = powerdown_flag_o;
    if (clear_watchdog_i || sleep_i) begin
      timeout_d = 1'b1;
    end
    if (watchdog_timeout_i) begin
      timeout_d = 1'b0;
    end
    if (clear_watchdog_i) begin
      powerdown_d = 1'b1;
    end
    if (sleep_i) begin
      powerdown_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (por_i) begin
      timeout_flag_o <= `TIMEOUT_POR;
      powerdown_flag_o <= `POWERDOWN_POR;
    end else begin
      timeout_flag_o <= timeout_d;
      powerdown_flag_o <= powerdown_d;
    end
  end

  // ==========================================================
  // Checks
  timeout_clear_a : assert property (@(posedge sys_clk_i) disable iff (por_i)
    watchdog_timeout_i |=> !timeout_flag_o)
    else $error("time-out flag not cleared by watchdog time-out");

  sleep_pd_a : assert property (@(posedge sys_clk_i) disable iff (por_i)
    sleep_i && !watchdog_timeout_i |=> !powerdown_flag_o && timeout_flag_o)
    else $error("sleep did not clear power-down and set time-out");

endmodule // reset_cause_flags

`default_nettype wire

// ---- cpu_status_flag_register.sv ----
// CPU status register: flags, reset cause and bank bits
`timescale 1ns/1ps
`default_nettype none
`include "status_flags_cfg.svh"

module cpu_status_flag_register (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic por_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic instr_valid_i,
  input wire cpu_status_pkg::alu_op_e instr_op_i,
  input wire logic [7:0] instr_freg_i,
  input wire logic [7:0] instr_w_i,
  input wire logic [2:0] instr_bit_i,
  input wire logic instr_dest_status_i,
  input wire logic watchdog_timeout_i,
  output logic [7:0] result_o,
  output logic result_valid_o,
  output logic [7:0] status_o
);

  // ==========================================================
  // State
  logic [2:0] bank_q;
  logic [2:0] bank_d;
  logic zero_q;
  logic zero_d;
  logic dc_q;
  logic dc_d;
  logic carry_q;
  logic carry_d;
  logic [7:0] result_d;
  logic result_valid_d;
  logic [7:0] rdata_d;
  logic timeout_flag;
  logic powerdown_flag;
  logic [7:0] status_cur;
  logic [7:0] freg;
  logic any_reset;
  logic bus_hit_wr;
  logic instr_go;

  logic [7:0] alu_result;
  logic alu_writes_f;
  logic alu_zero;
  logic alu_dc;
  logic alu_carry;
  logic alu_zero_en;
  logic alu_dc_en;
  logic alu_carry_en;
  logic any_flag_en;

  assign status_cur = {bank_q, timeout_flag, powerdown_flag, zero_q, dc_q, carry_q};
  assign any_reset = reset_i || por_i;
  assign bus_hit_wr = wr_i && (addr_i == `STATUS_ADDR);
  assign instr_go = instr_valid_i && !any_reset;
  // Read-modify-write instructions on the status register see its own value
  assign freg = instr_dest_status_i ? status_cur : instr_freg_i;
  assign any_flag_en = alu_zero_en || alu_dc_en || alu_carry_en;

  // ==========================================================
  // Flag logic
  status_alu u_alu (
    .op_i(instr_op_i),
    .freg_i(freg),
    .w_i(instr_w_i),
    .bit_sel_i(instr_bit_i),
    .carry_i(carry_q),
    .result_o(alu_result),
    .writes_f_o(alu_writes_f),
    .zero_o(alu_zero),
    .digit_carry_o(alu_dc),
    .carry_o(alu_carry),
    .zero_en_o(alu_zero_en),
    .digit_carry_en_o(alu_dc_en),
    .carry_en_o(alu_carry_en)
  );

  // ==========================================================
  // Reset-cause bits
  reset_cause_flags u_cause (
    .sys_clk_i(sys_clk_i),
    .por_i(por_i),
    .clear_watchdog_i(instr_go && (instr_op_i == cpu_status_pkg::OP_CLEAR_WATCHDOG)),
    .sleep_i(instr_go && (instr_op_i == cpu_status_pkg::OP_SLEEP)),
    .watchdog_timeout_i(watchdog_timeout_i),
    .timeout_flag_o(timeout_flag),
    .powerdown_flag_o(powerdown_flag)
  );

  // ==========================================================
  // Register next values; instruction overrides a same-cycle bus write
  always_comb begin
    bank_d = bank_q;
    zero_d = zero_q;
    dc_d = dc_q;
    carry_d = carry_q;
    if (bus_hit_wr) begin
      // Time-out and power-down positions are dropped
      bank_d = wdata_i[`BANK_MSB:`BANK_LSB];
      zero_d = wdata_i[`ZERO_BIT];
      dc_d = wdata_i[`DIGIT_CARRY_BIT];
      carry_d = wdata_i[`CARRY_BIT];
    end
    if (instr_go) begin
      if (instr_dest_status_i && alu_writes_f) begin
        bank_d = alu_result[`BANK_MSB:`BANK_LSB];
        if (!any_flag_en) begin
          zero_d = alu_result[`ZERO_BIT];
          dc_d = alu_result[`DIGIT_CARRY_BIT];
          carry_d = alu_result[`CARRY_BIT];
        end
      end
      if (alu_zero_en) begin
        zero_d = alu_zero;
      end
      if (alu_dc_en) begin
        dc_d = alu_dc;
      end
      if (alu_carry_en) begin
        carry_d = alu_carry;
      end
    end
    result_d = instr_go ? alu_result : result_o;
    result_valid_d = instr_go;
    rdata_d = (rd_i && (addr_i == `STATUS_ADDR)) ? status_cur : `READ_IDLE;
  end

  always_ff @(posedge sys_clk_i) begin
    if (any_reset) begin
      bank_q <= `BANK_RESET;
      result_valid_o <= 1'b0;
      result_o <= 8'h00;
      rdata_o <= `READ_IDLE;
    end else begin
      bank_q <= bank_d;
      result_valid_o <= result_valid_d;
      result_o <= result_d;
      rdata_o <= rdata_d;
    end
  end

  // Flags have no reset value and ride through every reset
  always_ff @(posedge sys_clk_i) begin
    zero_q <= zero_d;
    dc_q <= dc_d;
    carry_q <= carry_d;
  end

  always_ff @(posedge sys_clk_i) begin
    if (any_reset) begin
      status_o <= {`BANK_RESET, `TIMEOUT_POR, `POWERDOWN_POR, 3'h0};
    end else begin
      status_o <= {bank_d, timeout_flag, powerdown_flag, zero_d, dc_d, carry_d};
    end
  end

  // ==========================================================
  // Checks
  sequence seq_bus_write;
    bus_hit_wr && !instr_go && !any_reset;
  endsequence

  sequence seq_sub_issue;
    instr_go && (instr_op_i == cpu_status_pkg::OP_SUB);
  endsequence

  sequence seq_clear_status;
    instr_go && instr_dest_status_i && (instr_op_i == cpu_status_pkg::OP_CLEAR_REG);
  endsequence

  sequence seq_add_issue;
    instr_go && (instr_op_i == cpu_status_pkg::OP_ADD);
  endsequence

  sequence seq_move_status;
    instr_go && instr_dest_status_i && (instr_op_i == cpu_status_pkg::OP_MOVE_W);
  endsequence

  sequence seq_status_read;
    rd_i && (addr_i == `STATUS_ADDR);
  endsequence

  bus_write_a : assert property (@(posedge sys_clk_i) disable iff (any_reset)
    seq_bus_write |=> (bank_q == $past(wdata_i[7:5])) && ({zero_q, dc_q, carry_q} == $past(wdata_i[2:0])))
    else $error("bus write did not land in status register");

  cause_bits_a : assert property (@(posedge sys_clk_i) disable iff (any_reset)
    seq_bus_write and (instr_op_i == cpu_status_pkg::OP_NONE) and !watchdog_timeout_i
      |=> $stable(timeout_flag) && $stable(powerdown_flag))
    else $error("bus write changed a reset-cause bit");

  flag_block_a : assert property (@(posedge sys_clk_i) disable iff (any_reset)
    instr_go && instr_dest_status_i && (instr_op_i == cpu_status_pkg::OP_ADD)
      |=> (zero_q == $past(alu_zero)) && (carry_q == $past(alu_carry)) && (dc_q == $past(alu_dc)))
    else $error("flag bits took data instead of flag logic");

  clear_status_a : assert property (@(posedge sys_clk_i) disable iff (any_reset)
    seq_clear_status |=> (bank_q == 3'h0) && zero_q && $stable(dc_q) && $stable(carry_q)
      && (status_o[7:5] == 3'h0))
    else $error("clear of status register gave wrong pattern");

  bank_reset_a : assert property (@(posedge sys_clk_i) disable iff (1'b0)
    reset_i ##1 !any_reset |-> (bank_q == 3'h0) && (status_o[7:5] == 3'h0))
    else $error("bank bits not cleared by reset");

  flags_hold_a : assert property (@(posedge sys_clk_i) disable iff (1'b0)
    any_reset && !bus_hit_wr |=> $stable(zero_q) && $stable(dc_q) && $stable(carry_q))
    else $error("arithmetic flags disturbed by reset");

  borrow_a : assert property (@(posedge sys_clk_i) disable iff (any_reset)
    seq_sub_issue |=> carry_q == ($past(freg) >= $past(instr_w_i)))
    else $error("borrow polarity wrong");

  digit_borrow_a : assert property (@(posedge sys_clk_i) disable iff (any_reset)
    seq_sub_issue |=> dc_q == ($past(freg[3:0]) >= $past(instr_w_i[3:0])))
    else $error("digit borrow wrong");

  sub_result_a : assert property (@(posedge sys_clk_i) disable iff (any_reset)
    seq_sub_issue |=> result_valid_o && (result_o == $past(freg) - $past(instr_w_i)))
    else $error("subtraction result wrong");

  rotate_a : assert property (@(posedge sys_clk_i) disable iff (any_reset)
    instr_go && (instr_op_i == cpu_status_pkg::OP_ROT_RIGHT) |=> carry_q == $past(freg[0]))
    else $error("rotate right did not load carry from bit 0");

  read_data_a : assert property (@(posedge sys_clk_i) disable iff (any_reset)
    seq_status_read |=> (rdata_o == $past(status_cur)) ##1 ($past(rd_i) || (rdata_o == 8'h00)))
    else $error("status read data wrong");

  read_idle_a : assert property (@(posedge sys_clk_i) disable iff (any_reset)
    !(rd_i && (addr_i == `STATUS_ADDR)) |=> rdata_o == 8'h00)
    else $error("read data not idle without a status read");

  valid_pulse_a : assert property (@(posedge sys_clk_i) disable iff (any_reset)
    1'b1 |=> result_valid_o == $past(instr_go))
    else $error("result valid does not follow the instruction");

  result_hold_a : assert property (@(posedge sys_clk_i) disable iff (any_reset)
    !instr_go |=> $stable(result_o))
    else $error("result changed without an instruction");

  move_status_a : assert property (@(posedge sys_clk_i) disable iff (any_reset)
    seq_move_status |=> (bank_q == $past(instr_w_i[7:5])) && ({zero_q, dc_q, carry_q} == $past(instr_w_i[2:0])))
    else $error("move to status did not land");

  cause_hold_a : assert property (@(posedge sys_clk_i) disable iff (any_reset)
    instr_go && instr_dest_status_i && !watchdog_timeout_i && (instr_op_i != cpu_status_pkg::OP_CLEAR_WATCHDOG)
      && (instr_op_i != cpu_status_pkg::OP_SLEEP) |=> $stable(timeout_flag) && $stable(powerdown_flag))
    else $error("instruction write changed a reset-cause bit");

  bank_hold_a : assert property (@(posedge sys_clk_i) disable iff (any_reset)
    !bus_hit_wr && !(instr_go && instr_dest_status_i) |=> $stable(bank_q))
    else $error("bank bits changed without a write");

  // ==========================================================
  // Flag arithmetic worked out apart from the flag logic
  add_carry_a : assert property (@(posedge sys_clk_i) disable iff (any_reset)
    seq_add_issue |=> carry_q == (({1'b0, $past(freg)} + {1'b0, $past(instr_w_i)}) > 9'h0ff))
    else $error("add carry wrong");

  add_digit_a : assert property (@(posedge sys_clk_i) disable iff (any_reset)
    seq_add_issue |=> dc_q == (({1'b0, $past(freg[3:0])} + {1'b0, $past(instr_w_i[3:0])}) > 5'h0f))
    else $error("add digit carry wrong");

  add_zero_a : assert property (@(posedge sys_clk_i) disable iff (any_reset)
    seq_add_issue |=> zero_q == (($past(freg) + $past(instr_w_i)) == 8'h00))
    else $error("add zero flag wrong");

  and_zero_a : assert property (@(posedge sys_clk_i) disable iff (any_reset)
    instr_go && (instr_op_i == cpu_status_pkg::OP_AND)
      |=> zero_q == (($past(freg) & $past(instr_w_i)) == 8'h00))
    else $error("logic zero flag wrong");

  and_flags_a : assert property (@(posedge sys_clk_i) disable iff (any_reset)
    instr_go && instr_dest_status_i && (instr_op_i == cpu_status_pkg::OP_AND) && !bus_hit_wr
      |=> $stable(dc_q) && $stable(carry_q) && (bank_q == ($past(bank_q) & $past(instr_w_i[7:5]))))
    else $error("logic write to status disturbed blocked bits");

  rotate_left_a : assert property (@(posedge sys_clk_i) disable iff (any_reset)
    instr_go && (instr_op_i == cpu_status_pkg::OP_ROT_LEFT)
      |=> (carry_q == $past(freg[7])) && (result_o == {$past(freg[6:0]), $past(carry_q)}))
    else $error("rotate left did not move carry through bit 7");

  rotate_in_a : assert property (@(posedge sys_clk_i) disable iff (any_reset)
    instr_go && (instr_op_i == cpu_status_pkg::OP_ROT_RIGHT) |=> result_o == {$past(carry_q), $past(freg[7:1])})
    else $error("rotate right did not shift carry into bit 7");

endmodule // cpu_status_flag_register

`default_nettype wire

// ---- cpu_status_flag_register_tb_top.sv ----
// Self-checking testbench for the CPU status flag register
`timescale 1ns/1ps
`default_nettype none
`include "status_flags_cfg.svh"

module cpu_status_flag_register_tb_top;
  localparam logic [7:0] STAT = `STATUS_ADDR;
  localparam int MAX_CYCLES = 2000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic por = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic ivalid = 1'b0;
  cpu_status_pkg::alu_op_e iop = cpu_status_pkg::OP_NONE;
  logic [7:0] ifreg = 8'h00;
  logic [7:0] iw = 8'h00;
  logic [2:0] ibit = 3'h0;
  logic idest = 1'b0;
  logic wdt = 1'b0;
  logic [7:0] result;
  logic result_valid;
  logic [7:0] status;
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;

  // ==========================================================
  // Clock, timeout and design
  always #50 clk = ~clk;

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == MAX_CYCLES) begin
      n_mismatch = n_mismatch + 1;
      end_sim();
    end
  end

  cpu_status_flag_register u_cpu_status_flag_register (
    .sys_clk_i(clk), .reset_i(rst), .por_i(por), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .instr_valid_i(ivalid), .instr_op_i(iop),
    .instr_freg_i(ifreg), .instr_w_i(iw), .instr_bit_i(ibit), .instr_dest_status_i(idest),
    .watchdog_timeout_i(wdt), .result_o(result), .result_valid_o(result_valid), .status_o(status)
  );

  // ==========================================================
  // Shared tasks
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count = check_count + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", exp, rdata);
    @(posedge clk);
    #1;
    chk("rdata idle", 8'h00, rdata);
  endtask

  task automatic ins(input cpu_status_pkg::alu_op_e op, input logic [7:0] f, input logic [7:0] w,
                     input logic [2:0] b, input logic dest);
    @(posedge clk);
    ivalid <= 1'b1;
    iop <= op;
    ifreg <= f;
    iw <= w;
    ibit <= b;
    idest <= dest;
    @(posedge clk);
    ivalid <= 1'b0;
    #1;
    chk("result_valid", 8'h01, {7'h00, result_valid});
  endtask

  // ==========================================================
  // Scenarios
  task automatic test_por();
    chk("por upper bits", 8'h18, status & 8'hf8);
    $display("test por done");
  endtask

  task automatic test_bus();
    bus_wr(STAT, 8'he5);
    chk("bus write", 8'hfd, status);
    bus_rd(STAT, 8'hfd);
    bus_wr(8'h04, 8'h00);
    chk("other addr write", 8'hfd, status);
    bus_rd(8'h04, 8'h00);
    $display("test bus done");
  endtask

  task automatic test_cause();
    ins(cpu_status_pkg::OP_SLEEP, 8'h00, 8'h00, 3'h0, 1'b0);
    // Status output shows the reset-cause bits one cycle after they change
    @(posedge clk);
    wdt <= 1'b1;
    #1;
    chk("sleep", 8'hf5, status);
    @(posedge clk);
    wdt <= 1'b0;
    @(posedge clk);
    #1;
    chk("watchdog timeout", 8'he5, status);
    bus_wr(STAT, 8'hff);
    chk("cause bits write", 8'he7, status);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("other reset", 8'h07, status);
    ins(cpu_status_pkg::OP_CLEAR_WATCHDOG, 8'h00, 8'h00, 3'h0, 1'b0);
    @(posedge clk);
    #1;
    chk("clear watchdog", 8'h1f, status);
    $display("test reset cause done");
  endtask

  task automatic test_arith();
    bus_wr(STAT, 8'h00);
    ins(cpu_status_pkg::OP_SUB, 8'h05, 8'h03, 3'h0, 1'b0);
    chk("sub no borrow", 8'h02, result);
    chk("sub no borrow flags", 8'h1b, status);
    ins(cpu_status_pkg::OP_SUB, 8'h03, 8'h05, 3'h0, 1'b0);
    chk("sub borrow", 8'hfe, result);
    chk("sub borrow flags", 8'h18, status);
    ins(cpu_status_pkg::OP_SUB, 8'h05, 8'h05, 3'h0, 1'b0);
    chk("sub zero flags", 8'h1f, status);
    ins(cpu_status_pkg::OP_ADD, 8'h0f, 8'h01, 3'h0, 1'b0);
    chk("add digit carry", 8'h10, result);
    chk("add digit carry flags", 8'h1a, status);
    ins(cpu_status_pkg::OP_AND, 8'h0f, 8'hf0, 3'h0, 1'b0);
    chk("and zero flag", 8'h1e, status);
    ins(cpu_status_pkg::OP_ADD, 8'hf0, 8'h10, 3'h0, 1'b0);
    chk("add carry flags", 8'h1d, status);
    $display("test arithmetic done");
  endtask

  task automatic test_rot();
    ins(cpu_status_pkg::OP_ROT_RIGHT, 8'h02, 8'h00, 3'h0, 1'b0);
    chk("rotate right", 8'h81, result);
    chk("rotate right carry", 8'h1c, status);
    ins(cpu_status_pkg::OP_ROT_LEFT, 8'h80, 8'h00, 3'h0, 1'b0);
    chk("rotate left", 8'h00, result);
    chk("rotate left carry", 8'h1d, status);
    ins(cpu_status_pkg::OP_ROT_LEFT, 8'h7f, 8'h00, 3'h0, 1'b0);
    chk("rotate left in", 8'hff, result);
    chk("rotate left out", 8'h1c, status);
    $display("test rotate done");
  endtask

  task automatic test_dest();
    bus_wr(STAT, 8'h07);
    ins(cpu_status_pkg::OP_ADD, 8'h00, 8'h01, 3'h0, 1'b1);
    chk("add to status", 8'h3a, status);
    ins(cpu_status_pkg::OP_MOVE_W, 8'h00, 8'h00, 3'h0, 1'b1);
    chk("move to status", 8'h18, status);
    ins(cpu_status_pkg::OP_BIT_SET, 8'h00, 8'h00, 3'h0, 1'b1);
    chk("bit set status", 8'h19, status);
    ins(cpu_status_pkg::OP_NIBBLE_SWAP, 8'h00, 8'h00, 3'h0, 1'b1);
    chk("swap status", 8'h99, status);
    ins(cpu_status_pkg::OP_BIT_CLEAR, 8'h00, 8'h00, 3'h7, 1'b1);
    chk("bit clear status", 8'h19, status);
    $display("test status destination done");
  endtask

  task automatic test_clear();
    bus_wr(STAT, 8'he0);
    chk("before clear", 8'hf8, status);
    ins(cpu_status_pkg::OP_CLEAR_REG, 8'h00, 8'h00, 3'h0, 1'b1);
    chk("clear status", 8'h1c, status);
    ins(cpu_status_pkg::OP_AND, 8'h00, 8'hff, 3'h0, 1'b1);
    chk("and to status", 8'h1c, result);
    chk("and to status flags", 8'h18, status);
    $display("test clear done");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    @(posedge clk);
    #1;
    test_por();
    test_bus();
    test_cause();
    test_arith();
    test_rot();
    test_dest();
    test_clear();
    end_sim();
  end
endmodule // cpu_status_flag_register_tb_top

`default_nettype wire
